/* File: logic/flash_host_pkg.sv */
// Shared types and constants for the parallel NOR flash host controller.
// Assumes a 20 MHz system clock and a flash with a 16-bit data bus.
package flash_host_pkg;

	localparam int ADDR_W          = 22;
	localparam int DATA_W          = 16;
	localparam int CNT_W           = 9;
	localparam int TP_W            = 7;

	localparam int CLK_NS          = 50;
	localparam int SYNC_CYC        = 2;
	localparam int T_ACC_NS        = 90;
	localparam int T_WP_NS         = 35;
	localparam int T_POLL_US       = 4;
	localparam int T_RP_NS         = 500;
	localparam int T_READY_US      = 20;

	localparam int RD_CYC          = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
	localparam int WP_CYC          = (T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int TPOLL_CYC       = (T_POLL_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC          = (T_RP_NS + CLK_NS - 1) / CLK_NS;
	localparam int READY_CYC       = (T_READY_US * 1000 + CLK_NS - 1) / CLK_NS;

	localparam int BUF_MAX_WORDS   = 16;
	localparam int BUF_MAX_BYTES   = 32;

	localparam int DATA_POLL_BIT   = 7;
	localparam int TOGGLE_BIT      = 6;
	localparam int SUSP_TOGGLE_BIT = 2;
	localparam int PROT_SEL_BIT    = 6;
	localparam logic [3:0] PROT_LOW_PAT = 4'h2;

	typedef enum logic [2:0] {
		OP_READ    = 3'h0,
		OP_WRITE   = 3'h1,
		OP_POLL    = 3'h2,
		OP_PROTECT = 3'h3,
		OP_BUFCNT  = 3'h4,
		OP_SUSPEND = 3'h5,
		OP_RESUME  = 3'h6,
		OP_RESET   = 3'h7
	} op_t;

	typedef struct packed {
		op_t               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              byte_mode;
		logic              prog_start;
		logic              unprotect;
		logic              poll_data;
	} cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              done;
		logic              susp_toggle;
		logic              err;
	} rsp_t;

	typedef enum logic [8:0] {
		S_IDLE   = 9'h001,
		S_WR_SET = 9'h002,
		S_WR_PUL = 9'h004,
		S_WR_HLD = 9'h008,
		S_RD     = 9'h010,
		S_RD_GAP = 9'h020,
		S_PWAIT  = 9'h040,
		S_RST_LO = 9'h080,
		S_RST_WT = 9'h100
	} state_t;

	typedef struct packed {
		state_t            st;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              rst_n;
		logic              dq_oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic [CNT_W-1:0]  cnt;
		logic [TP_W-1:0]   tpoll;
		logic              reapply;
		logic              rd_first;
		logic [DATA_W-1:0] first;
		cmd_t              cmd;
		rsp_t              rsp;
		logic              rsp_valid;
		logic              cmd_ready;
	} ctl_t;

endpackage : flash_host_pkg

/* File: logic/flash_host.sv */
// Host-side controller that drives an asynchronous parallel NOR flash by its pins.
// Assumes the flash data bus is resolved outside from DQ_OUT and DQ_OE_N.
//
// How it works
// - Host makes successive status reads by pulsing both output enable and chip select.
// - Data-poll status reads use the programmed location or erased sector address.
// - Low address bits 0xx0010 select protect, 1xx0010 select unprotect.
// - One buffer program carries 1 to 16 words or 1 to 32 bytes.
// - Suspend inside the program-to-poll interval forces a full wait after resume.
`timescale 1ns/1ps
module flash_host (
	input  wire logic                          CLK,
	input  wire logic                          ARST_N,
	input  wire logic                          CMD_VALID,
	input  wire flash_host_pkg::cmd_t          CMD,
	output logic                               CMD_READY,
	output logic                               RSP_VALID,
	output flash_host_pkg::rsp_t               RSP,
	output logic                               FLASH_CE_N,
	output logic                               FLASH_OE_N,
	output logic                               FLASH_WE_N,
	output logic                               FLASH_RESET_N,
	output logic [flash_host_pkg::ADDR_W-1:0]  FLASH_ADDR,
	output logic [flash_host_pkg::DATA_W-1:0]  DQ_OUT,
	output logic                               DQ_OE_N,
	input  wire logic [flash_host_pkg::DATA_W-1:0] DQ_IN
);
	import flash_host_pkg::*;

	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic              rst_s1;
	logic              rst_n;
	logic [DATA_W-1:0] dq_s1;
	logic [DATA_W-1:0] dq_s2;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			dq_s1 <= DQ_IN;
			dq_s2 <= dq_s1;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	ctl_t r_reg;
	ctl_t r_next;
	logic [DATA_W-1:0] buf_max;
	logic              buf_ok;

	assign buf_max = CMD.byte_mode ? DATA_W'(BUF_MAX_BYTES) : DATA_W'(BUF_MAX_WORDS);
	assign buf_ok  = (CMD.data != '0) && (CMD.data <= buf_max);

	always_comb begin
		r_next           = r_reg;
		r_next.rsp_valid = 1'b0;
		if (r_reg.tpoll != '0) begin
			r_next.tpoll = r_reg.tpoll - 1'b1;
		end
		unique case (r_reg.st)
			S_IDLE: begin
				if (CMD_VALID) begin
					r_next.cmd       = CMD;
					r_next.cmd_ready = 1'b0;
					r_next.addr      = CMD.addr;
					r_next.dout      = CMD.data;
					r_next.ce_n      = 1'b0;
					r_next.st        = S_WR_SET;
					r_next.dq_oe_n   = 1'b0;
					unique case (CMD.op)
						OP_READ: begin
							r_next.dq_oe_n = 1'b1;
							r_next.oe_n    = 1'b0;
							r_next.cnt     = CNT_W'(RD_CYC - 1);
							r_next.st      = S_RD;
						end
						OP_POLL: begin
							r_next.dq_oe_n = 1'b1;
							r_next.ce_n    = 1'b1;
							r_next.st      = S_PWAIT;
						end
						OP_PROTECT: begin
							r_next.addr[PROT_SEL_BIT] = CMD.unprotect;
							r_next.addr[3:0]          = PROT_LOW_PAT;
						end
						OP_BUFCNT: begin
							if (buf_ok) begin
								r_next.dout = CMD.data - 1'b1;
							end else begin
								r_next.dq_oe_n   = 1'b1;
								r_next.ce_n      = 1'b1;
								r_next.st        = S_IDLE;
								r_next.cmd_ready = 1'b1;
								r_next.rsp_valid = 1'b1;
								r_next.rsp       = '{data: '0, done: 1'b0,
									susp_toggle: 1'b0, err: 1'b1};
							end
						end
						OP_SUSPEND: begin
							r_next.reapply = (r_reg.tpoll != '0);
						end
						OP_RESUME: begin
							if (r_reg.reapply) begin
								r_next.tpoll   = TP_W'(TPOLL_CYC);
								r_next.reapply = 1'b0;
							end
						end
						OP_RESET: begin
							r_next.dq_oe_n = 1'b1;
							r_next.ce_n    = 1'b1;
							r_next.rst_n   = 1'b0;
							r_next.cnt     = CNT_W'(RP_CYC - 1);
							r_next.tpoll   = '0;
							r_next.reapply = 1'b0;
							r_next.st      = S_RST_LO;
						end
						default: begin
							if (CMD.prog_start) begin
								r_next.tpoll = TP_W'(TPOLL_CYC);
							end
						end
					endcase
				end
			end
			S_WR_SET: begin
				r_next.we_n = 1'b0;
				r_next.cnt  = CNT_W'(WP_CYC - 1);
				r_next.st   = S_WR_PUL;
			end
			S_WR_PUL: begin
				if (r_reg.cnt == '0) begin
					r_next.we_n = 1'b1;
					r_next.st   = S_WR_HLD;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			S_WR_HLD: begin
				r_next.ce_n      = 1'b1;
				r_next.dq_oe_n   = 1'b1;
				r_next.st        = S_IDLE;
				r_next.cmd_ready = 1'b1;
				r_next.rsp_valid = 1'b1;
				r_next.rsp       = '{data: '0, done: 1'b1, susp_toggle: 1'b0, err: 1'b0};
			end
			S_PWAIT: begin
				// Status is not read until the program-to-poll interval has run out.
				if (r_reg.tpoll == '0) begin
					r_next.ce_n     = 1'b0;
					r_next.oe_n     = 1'b0;
					r_next.rd_first = 1'b0;
					r_next.cnt      = CNT_W'(RD_CYC - 1);
					r_next.st       = S_RD;
				end
			end
			S_RD: begin
				if (r_reg.cnt != '0) begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end else begin
					r_next.ce_n = 1'b1;
					r_next.oe_n = 1'b1;
					if (r_reg.cmd.op == OP_POLL && !r_reg.rd_first) begin
						r_next.rd_first = 1'b1;
						r_next.first    = dq_s2;
						r_next.st       = S_RD_GAP;
					end else begin
						r_next.st        = S_IDLE;
						r_next.cmd_ready = 1'b1;
						r_next.rsp_valid = 1'b1;
						r_next.rsp.data  = dq_s2;
						r_next.rsp.done  = 1'b1;
						r_next.rsp.err   = 1'b0;
						r_next.rsp.susp_toggle = 1'b0;
						if (r_reg.cmd.op == OP_POLL) begin
							// Busy while the toggle bit moves between reads.
							r_next.rsp.done = ~(r_reg.first[TOGGLE_BIT] ^ dq_s2[TOGGLE_BIT]);
							r_next.rsp.susp_toggle = r_reg.first[SUSP_TOGGLE_BIT]
								^ dq_s2[SUSP_TOGGLE_BIT];
							r_next.rsp.err = r_reg.cmd.poll_data
								&& (r_reg.first[TOGGLE_BIT] == dq_s2[TOGGLE_BIT])
								&& (dq_s2[DATA_POLL_BIT] != r_reg.cmd.data[DATA_POLL_BIT]);
						end
					end
				end
			end
			S_RD_GAP: begin
				r_next.ce_n = 1'b0;
				r_next.oe_n = 1'b0;
				r_next.cnt  = CNT_W'(RD_CYC - 1);
				r_next.st   = S_RD;
			end
			S_RST_LO: begin
				if (r_reg.cnt == '0) begin
					r_next.rst_n = 1'b1;
					r_next.cnt   = CNT_W'(READY_CYC - 1);
					r_next.st    = S_RST_WT;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			S_RST_WT: begin
				if (r_reg.cnt == '0) begin
					r_next.st        = S_IDLE;
					r_next.cmd_ready = 1'b1;
					r_next.rsp_valid = 1'b1;
					r_next.rsp       = '{data: '0, done: 1'b1, susp_toggle: 1'b0, err: 1'b0};
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			default: r_next.st = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			r_reg           <= '0;
			r_reg.st        <= S_IDLE;
			r_reg.ce_n      <= 1'b1;
			r_reg.oe_n      <= 1'b1;
			r_reg.we_n      <= 1'b1;
			r_reg.rst_n     <= 1'b1;
			r_reg.dq_oe_n   <= 1'b1;
			r_reg.cmd_ready <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign CMD_READY     = r_reg.cmd_ready;
	assign RSP_VALID     = r_reg.rsp_valid;
	assign RSP           = r_reg.rsp;
	assign FLASH_CE_N    = r_reg.ce_n;
	assign FLASH_OE_N    = r_reg.oe_n;
	assign FLASH_WE_N    = r_reg.we_n;
	assign FLASH_RESET_N = r_reg.rst_n;
	assign FLASH_ADDR    = r_reg.addr;
	assign DQ_OUT        = r_reg.dout;
	assign DQ_OE_N       = r_reg.dq_oe_n;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	AST_PROT_PATTERN: assert property ($fell(r_reg.we_n)
		&& r_reg.cmd.op == OP_PROTECT |-> r_reg.addr[3:0] == PROT_LOW_PAT
		&& r_reg.addr[PROT_SEL_BIT] == r_reg.cmd.unprotect)
		else $error("Protect address pattern wrong.");
	AST_BUF_RANGE: assert property ($fell(r_reg.we_n) && r_reg.cmd.op == OP_BUFCNT
		|-> r_reg.dout < (r_reg.cmd.byte_mode ? DATA_W'(BUF_MAX_BYTES)
		: DATA_W'(BUF_MAX_WORDS)))
		else $error("Buffer count out of range written.");
	AST_TPOLL_WAIT: assert property ($fell(r_reg.oe_n) && r_reg.cmd.op == OP_POLL
		|-> $past(r_reg.tpoll) == '0)
		else $error("Status read before poll interval ended.");
	AST_RST_PULSE: assert property ($fell(r_reg.rst_n) |-> !r_reg.rst_n [*8])
		else $error("Reset pulse too short.");
	AST_RST_WAIT: assert property ($rose(r_reg.rst_n) |-> ##[399:401] r_reg.rsp_valid)
		else $error("Reset recovery wait wrong.");
	AST_POLL_GAP: assert property (r_reg.st == S_RD_GAP
		|-> r_reg.oe_n && r_reg.ce_n ##1 !r_reg.oe_n && !r_reg.ce_n)
		else $error("Status reads not separated by a pulse.");
	AST_POLL_ADDR: assert property (!r_reg.oe_n && r_reg.cmd.op == OP_POLL
		|-> r_reg.addr == r_reg.cmd.addr) else $error("Poll address moved.");
	AST_POLL_DONE: assert property (r_reg.rsp_valid
		&& r_reg.cmd.op == OP_POLL |-> r_reg.rsp.done
		== (r_reg.rsp.data[TOGGLE_BIT] == r_reg.first[TOGGLE_BIT]))
		else $error("Done while toggling.");
	AST_SUSP_TOG: assert property (r_reg.rsp_valid && r_reg.cmd.op == OP_POLL
		|-> r_reg.rsp.susp_toggle == (r_reg.first[SUSP_TOGGLE_BIT] ^ r_reg.rsp.data[SUSP_TOGGLE_BIT]))
		else $error("Suspend toggle report wrong.");
	AST_DPOLL: assert property (r_reg.rsp_valid && r_reg.cmd.op == OP_POLL
		&& r_reg.rsp.done && r_reg.cmd.poll_data |-> r_reg.rsp.err
		== (r_reg.rsp.data[DATA_POLL_BIT] != r_reg.cmd.data[DATA_POLL_BIT]))
		else $error("Data poll mismatch not flagged.");

	COV_POLL_BUSY: cover property (r_reg.rsp_valid && r_reg.cmd.op == OP_POLL && !r_reg.rsp.done);
	COV_POLL_DONE: cover property (r_reg.rsp_valid && r_reg.cmd.op == OP_POLL && r_reg.rsp.done);
	COV_REAPPLY:   cover property (r_reg.cmd.op == OP_RESUME && r_reg.tpoll == 7'(TPOLL_CYC));
	COV_BUF_ERR:   cover property (r_reg.rsp_valid && r_reg.rsp.err);

endmodule : flash_host

/* File: dv/flash_dev_model.sv */
// Behavioural parallel NOR flash that answers the host controller's pins.
// Assumes a write of 00b0 suspends an erase and 0030 resumes; other writes start a program.
`timescale 1ns/1ps
module flash_dev_model #(
	parameter int BUSY_NS = 20000
) (
	input  wire logic        CE_N,
	input  wire logic        OE_N,
	input  wire logic        WE_N,
	input  wire logic        RESET_N,
	input  wire logic [21:0] ADDR,
	input  wire logic [15:0] DQ_W,
	input  wire logic        DQ_OE_N,
	output logic      [15:0] DQ
);
	logic        busy = 1'b0, susp = 1'b0, tog = 1'b0, tog2 = 1'b0;
	logic [15:0] wdata = '0, last = '0, st;
	logic [6:0]  ssec = '0;
	time         t_end = 0;
	// A write closes on the rising edge of write enable.
	always @(posedge WE_N) if (!CE_N && RESET_N) begin
		if (DQ_W == 16'h00b0) begin
			busy = 1'b0;
			susp = 1'b1;
			ssec = ADDR[21:15];
		end else begin
			busy = 1'b1;
			susp = 1'b0;
			t_end = $time + BUSY_NS;
			if (DQ_W != 16'h0030) wdata = DQ_W;
		end
	end
	always #50 if (busy && $time >= t_end) busy = 1'b0;
	always @(negedge RESET_N) begin
		busy = 1'b0;
		susp = 1'b0;
	end
	// Status bits step each time output enable lifts while busy, or while suspended and addressing the suspended sector.
	always @(posedge OE_N) begin
		if (busy) tog = ~tog;
		else if (susp && ADDR[21:15] == ssec) tog2 = ~tog2;
	end
	// A released bus shows the inverse of its last value, never a stale copy.
	always @* begin
		st = 16'h0;
		st[7] = ~wdata[7];
		st[6] = tog;
		st[2] = tog2;
		if (!DQ_OE_N) DQ = DQ_W;
		else if (CE_N || OE_N) DQ = ~last;
		else if (busy || (susp && ADDR[21:15] == ssec)) DQ = st;
		else DQ = ADDR[15:0] ^ 16'h5a5a;
	end
	always @(DQ) if (!CE_N && !OE_N) last = DQ;
endmodule : flash_dev_model

/* File: dv/tb.sv */
// Self-checking testbench for the flash host controller.
// Assumes the behavioural flash in flash_dev_model.sv on the far side.
`timescale 1ns/1ps
module tb;
	import flash_host_pkg::*;
	logic        clk = 0, arst_n = 0, cmd_valid = 0;
	cmd_t        cmd = '0;
	logic        cmd_ready, rsp_valid, ce_n, oe_n, we_n, frst_n, dq_oe_n, e;
	rsp_t        rsp, r;
	logic [21:0] addr, wa, a;
	logic [15:0] dq_out, dq_in, wd, d;
	int          n_errors = 0, checks = 0, lat, nwr = 0, nrst = 0, i, k;
	int          bn[7] = '{0, 1, 16, 17, 1, 32, 33};
	always #25 clk = ~clk;
	always @(negedge we_n) begin
		wa = addr;
		wd = dq_out;
		nwr++;
	end
	always @(negedge frst_n) nrst++;
	flash_host uut (.CLK(clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD(cmd),
		.CMD_READY(cmd_ready), .RSP_VALID(rsp_valid), .RSP(rsp), .FLASH_CE_N(ce_n),
		.FLASH_OE_N(oe_n), .FLASH_WE_N(we_n), .FLASH_RESET_N(frst_n), .FLASH_ADDR(addr),
		.DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .DQ_IN(dq_in));
	flash_dev_model dev (.CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .RESET_N(frst_n),
		.ADDR(addr), .DQ_W(dq_out), .DQ_OE_N(dq_oe_n), .DQ(dq_in));
	task automatic check(logic [63:0] seen, logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// Flag bits are byte_mode, prog_start, unprotect, poll_data.
	function automatic cmd_t mk(op_t o, logic [21:0] ad, logic [15:0] dt, logic [3:0] f);
		mk = {o, ad, dt, f};
	endfunction : mk
	// Offers one command and counts edges until its response is seen.
	task automatic run(cmd_t c);
		cmd_valid <= 1'b1;
		cmd <= c;
		@(posedge clk);
		cmd_valid <= 1'b0;
		lat = 0;
		while (rsp_valid !== 1'b1) begin
			@(posedge clk);
			lat++;
			if (lat > 2000) begin
				n_errors++;
				end_sim;
			end
		end
		r = rsp;
	endtask : run
	initial begin
		i = $urandom(32'h1800);
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check({ce_n, oe_n, we_n, frst_n, dq_oe_n, cmd_ready}, 6'h3f);
		for (i = 0; i < 4; i++) begin
			a = 22'($urandom);
			run(mk(OP_READ, a, 16'h0, 4'h0));
			check(r.data, a[15:0] ^ 16'h5a5a);
			check(lat, RD_CYC + 1);
		end
		a = 22'($urandom);
		// Bit 8 set keeps the data clear of the model's suspend and resume codes.
		d = 16'($urandom) | 16'h0100;
		run(mk(OP_WRITE, a, d, 4'h4));
		check({wa, wd}, {a, d});
		check(lat, 4);
		run(mk(OP_POLL, a, d, 4'h1));
		check(lat >= TPOLL_CYC, 1);
		check({r.data[7], r.done, r.err}, {~d[7], 2'b00});
		run(mk(OP_POLL, ~a, 16'h0, 4'h0));
		check(r.done, 0);
		i = 0;
		do run(mk(OP_POLL, a, d, 4'h1)); while (r.done !== 1'b1 && ++i < 80);
		check({r.data, r.err}, {a[15:0] ^ 16'h5a5a, a[7] ^ d[7]});
		a = {7'h11, 15'($urandom)};
		run(mk(OP_WRITE, a, d, 4'h4));
		run(mk(OP_SUSPEND, a, 16'h00b0, 4'h0));
		run(mk(OP_POLL, a, 16'h0, 4'h0));
		check(r.susp_toggle, 1);
		run(mk(OP_POLL, {7'h12, a[14:0]}, 16'h0, 4'h0));
		check(r.susp_toggle, 0);
		run(mk(OP_RESUME, a, 16'h0030, 4'h0));
		run(mk(OP_POLL, a, d, 4'h1));
		check(lat >= TPOLL_CYC, 1);
		run(mk(OP_WRITE, a, d, 4'h4));
		repeat (100) @(posedge clk);
		run(mk(OP_SUSPEND, a, 16'h00b0, 4'h0));
		run(mk(OP_RESUME, a, 16'h0030, 4'h0));
		run(mk(OP_POLL, a, d, 4'h1));
		check(lat, 11);
		run(mk(OP_WRITE, a, d, 4'h4));
		k = nrst;
		run(mk(OP_RESET, a, 16'h0, 4'h0));
		check({nrst - k, lat}, {32'd1, 32'(RP_CYC + READY_CYC + 1)});
		run(mk(OP_POLL, a, d, 4'h0));
		check({r.done, r.err}, 2'b10);
		for (i = 0; i < 2; i++) begin
			a = 22'($urandom);
			run(mk(OP_PROTECT, a, 16'h0060, {2'b00, i[0], 1'b0}));
			check(wa, {a[21:7], i[0], a[5:4], 4'h2});
		end
		for (i = 0; i < 7; i++) begin
			k = nwr;
			e = bn[i] == 0 || bn[i] > (i < 4 ? BUF_MAX_WORDS : BUF_MAX_BYTES);
			run(mk(OP_BUFCNT, a, 16'(bn[i]), {i >= 4, 3'h0}));
			check(r.err, e);
			check({nwr - k, lat}, {32'(!e), 32'(e ? 1 : 4)});
			if (!e) check(wd, 16'(bn[i] - 1));
		end
		end_sim;
	end
endmodule : tb
